/* File: design/prbs_pkg.sv */
// Shared types, constants and helpers for the pattern self-test block
package prbs_pkg;

	typedef enum logic [2:0] {
		PAT_OFF = 3'b000,
		PAT_PRBS7 = 3'b001,
		PAT_PRBS8 = 3'b010,
		PAT_PRBS10 = 3'b011,
		PAT_PRBS23 = 3'b100,
		PAT_HIGH = 3'b101,
		PAT_LOW = 3'b110
	} pattern_e;

	typedef enum logic [1:0] {
		GEN_ALIGN_HI = 2'b00,
		GEN_ALIGN_LO = 2'b01,
		GEN_RUN = 2'b10
	} gen_phase_e;

	typedef enum logic [2:0] {
		VER_IDLE = 3'b000,
		VER_SEARCH = 3'b001,
		VER_WARM = 3'b010,
		VER_COUNT = 3'b011,
		VER_DONE = 3'b100
	} ver_e;

	typedef struct packed {
		pattern_e pattern;
		logic width10;
		logic basic_mode;
		logic loopback_en;
	} selftest_cfg_s;

	typedef struct packed {
		logic done;
		logic err;
		logic aligned;
	} verify_status_s;

	typedef struct packed {
		logic [22:0] hist;
		logic [9:0] word;
	} prbs_step_s;

	localparam logic [15:0] ALIGN_PRBS7 = 16'h3040;
	localparam logic [15:0] ALIGN_PRBS8 = 16'hff5a;
	localparam logic [15:0] ALIGN_PRBS23 = 16'hffff;
	localparam logic [9:0] ALIGN_PRBS10 = 10'h3ff;
	// Bit 0 leaves the serializer first
	localparam logic [9:0] HIGH_WORD10 = 10'h155;
	localparam logic [7:0] HIGH_WORD8 = 8'h55;
	localparam logic [9:0] LOW_WORD10 = 10'h01f;
	localparam logic [9:0] MASK10 = 10'h3ff;
	localparam logic [9:0] MASK8 = 10'h0ff;
	localparam logic [22:0] HIST_SEED = 23'h7fffff;
	localparam logic [9:0] WORD_RESET = 10'h000;
	localparam logic [4:0] DEG7 = 5'd7;
	localparam logic [4:0] TAP7 = 5'd6;
	localparam logic [4:0] DEG8 = 5'd8;
	localparam logic [4:0] TAP8 = 5'd7;
	localparam logic [4:0] DEG10 = 5'd10;
	localparam logic [4:0] TAP10 = 5'd7;
	localparam logic [4:0] DEG23 = 5'd23;
	localparam logic [4:0] TAP23 = 5'd18;
	localparam logic [23:0] CYCLE_WORDS7 = 24'((2**(7-1) + 7) / 8);
	localparam logic [23:0] CYCLE_WORDS8 = 24'((2**(8-1) + 7) / 8);
	localparam logic [23:0] CYCLE_WORDS10 = 24'((2**(10-1) + 9) / 10);
	localparam int unsigned CYCLE_WORDS23 = (2**(23-1) + 7) / 8;
	localparam logic [1:0] WARM_WORDS = 2'd3;
	localparam logic [1:0] ERR_HOLD_CYCLES = 2'd3;

	function automatic logic is_prbs(input pattern_e p);
		is_prbs = (p == PAT_PRBS7) || (p == PAT_PRBS8) ||
			(p == PAT_PRBS10) || (p == PAT_PRBS23);
	endfunction

	function automatic logic pattern_ok(input pattern_e p, input logic w10);
		case (p)
			PAT_PRBS7, PAT_PRBS8, PAT_PRBS23: pattern_ok = !w10;
			PAT_PRBS10, PAT_LOW: pattern_ok = w10;
			PAT_HIGH: pattern_ok = 1'b1;
			default: pattern_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [9:0] taps(input pattern_e p);
		case (p)
			PAT_PRBS8: taps = {DEG8, TAP8};
			PAT_PRBS10: taps = {DEG10, TAP10};
			PAT_PRBS23: taps = {DEG23, TAP23};
			default: taps = {DEG7, TAP7};
		endcase
	endfunction

	function automatic logic [15:0] align16(input pattern_e p);
		case (p)
			PAT_PRBS8: align16 = ALIGN_PRBS8;
			PAT_PRBS23: align16 = ALIGN_PRBS23;
			default: align16 = ALIGN_PRBS7;
		endcase
	endfunction

	// One parallel word of a Fibonacci sequence; follow_rx self-seeds
	function automatic prbs_step_s prbs_step(input logic [22:0] h,
			input logic [9:0] tp, input logic w10, input logic [9:0] rx,
			input logic follow_rx);
		prbs_step_s s;
		logic b;
		int i;
		s.hist = h;
		s.word = WORD_RESET;
		for (i = 0; i < 10; i++) begin
			if (i < 8 || w10) begin
				b = s.hist[tp[9:5] - 5'd1] ^ s.hist[tp[4:0] - 5'd1];
				s.word[i] = b;
				s.hist = {s.hist[21:0], follow_rx ? rx[i] : b};
			end
		end
		return s;
	endfunction

endpackage

/* File: design/prbs_pattern_gen.sv */
// Transmit-side pattern generator feeding the serializer word
`timescale 1ns/1ps
module prbs_pattern_gen (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tx_digitalreset,
	// Configuration
	input prbs_pkg::selftest_cfg_s cfg,
	// Parallel word to the serializer
	output logic [9:0] tx_word
);
	import prbs_pkg::*;

	typedef struct packed {
		gen_phase_e phase;
		logic [22:0] hist;
		logic [9:0] word;
	} gen_state_s;

	localparam gen_state_s GEN_RESET = '{GEN_ALIGN_HI, HIST_SEED, WORD_RESET};

	gen_state_s gen_r;
	gen_state_s gen_nxt;
	prbs_step_s step;
	logic [15:0] al;

	always_comb begin
		gen_nxt = gen_r;
		al = align16(cfg.pattern);
		step = prbs_step(gen_r.hist, taps(cfg.pattern), cfg.width10,
			WORD_RESET, 1'b0);
		if (!cfg.basic_mode || !pattern_ok(cfg.pattern, cfg.width10)) begin
			gen_nxt = GEN_RESET;
		end else if (cfg.pattern == PAT_HIGH) begin
			gen_nxt.word = cfg.width10 ? HIGH_WORD10 : {2'b00, HIGH_WORD8};
		end else if (cfg.pattern == PAT_LOW) begin
			gen_nxt.word = LOW_WORD10;
		end else begin
			// Alignment word first so the far word aligner can lock
			case (gen_r.phase)
				GEN_ALIGN_HI: begin
					gen_nxt.word = cfg.width10 ? ALIGN_PRBS10 : {2'b00, al[15:8]};
					gen_nxt.phase = cfg.width10 ? GEN_RUN : GEN_ALIGN_LO;
				end
				GEN_ALIGN_LO: begin
					gen_nxt.word = {2'b00, al[7:0]};
					gen_nxt.phase = GEN_RUN;
				end
				GEN_RUN: begin
					// Free-running register wraps on its own
					gen_nxt.word = step.word;
					gen_nxt.hist = step.hist;
				end
				default: gen_nxt.phase = GEN_ALIGN_HI;
			endcase
		end
		if (!rst_b || tx_digitalreset) begin
			gen_nxt = GEN_RESET;
		end
	end

	always_ff @(posedge clk) begin
		gen_r <= gen_nxt;
	end

	assign tx_word = gen_r.word;

endmodule // prbs_pattern_gen

/* File: design/prbs_selftest.sv */
// Per-channel pattern self-test: generator, loopback and verifier
//
// Summary of operation
// - The generator drives the word ahead of the serializer and the verifier checks words after the aligner.
// - Each pseudo-random sequence repeats forever, one cycle being 2^(X-1) bits long for degree X.
// - Degree 7 uses x^7+x^6+1, 8-bit width only, aligned on 16'h3040.
// - Degree 8 uses x^8+x^7+1, 8-bit width only, aligned on 16'hff5a.
// - Degree 10 uses x^10+x^7+1, 10-bit width only, aligned on 10'h3ff.
// - Degree 23 uses x^23+x^18+1, 8-bit width only, aligned on 16'hffff.
// - High frequency is alternating ones and zeros at either width; low frequency is five and five at 10 bits only.
// - The generated word is 8 or 10 bits wide as the channel width says.
// - The toggle patterns get no checking and never touch the flags.
// - Optional serial loopback returns the generated word to the verifier input.
// - After alignment, done rises after one full pattern cycle and holds until receive reset.
// - After done, error is raised for at least three cycles on a mismatch and drops after a clean cycle.
// - Transmit reset clears the generator and receive reset clears the verifier.
// - Pattern generation and checking run only in the basic functional mode.
`timescale 1ns/1ps
module prbs_selftest #(
	parameter int unsigned PRBS23_CYCLE_WORDS = prbs_pkg::CYCLE_WORDS23
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tx_digitalreset,
	input wire logic rx_digitalreset,
	// Configuration from fabric
	input prbs_pkg::selftest_cfg_s cfg,
	// Serial side, parallel words
	output logic [9:0] tx_word,
	input wire logic [9:0] rx_word,
	// Verifier status
	output prbs_pkg::verify_status_s status
);
	import prbs_pkg::*;

	typedef struct packed {
		ver_e st;
		logic [9:0] rx_d;
		logic [9:0] rx_prev;
		logic [22:0] hist;
		logic [23:0] cnt;
		logic [1:0] warm;
		logic [1:0] hold;
		logic dirty;
		logic done;
		logic err;
		logic aligned;
	} ver_state_s;

	localparam ver_state_s VER_RESET = '{VER_IDLE, WORD_RESET, WORD_RESET,
		HIST_SEED, 24'h000000, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0};

	ver_state_s ver_r;
	ver_state_s ver_nxt;
	prbs_step_s step;
	logic [9:0] rx_src;
	logic [9:0] mask;
	logic [23:0] cyc;
	logic ver_en;
	logic mism;
	logic match;
	logic cyc_end;

	function automatic logic [23:0] cycle_words(input pattern_e p);
		case (p)
			PAT_PRBS7: cycle_words = CYCLE_WORDS7;
			PAT_PRBS8: cycle_words = CYCLE_WORDS8;
			PAT_PRBS10: cycle_words = CYCLE_WORDS10;
			PAT_PRBS23: cycle_words = PRBS23_CYCLE_WORDS[23:0];
			default: cycle_words = CYCLE_WORDS7;
		endcase
	endfunction

	prbs_pattern_gen u_gen (
		.clk(clk),
		.rst_b(rst_b),
		.tx_digitalreset(tx_digitalreset),
		.cfg(cfg),
		.tx_word(tx_word)
	);

	// Loopback taps the word before it reaches the serial pins
	assign rx_src = cfg.loopback_en ? tx_word : rx_word;

	always_comb begin
		ver_nxt = ver_r;
		mask = cfg.width10 ? MASK10 : MASK8;
		cyc = cycle_words(cfg.pattern);
		ver_en = cfg.basic_mode && is_prbs(cfg.pattern) &&
			pattern_ok(cfg.pattern, cfg.width10);
		// Self-seeding check: expected bits come from received history
		step = prbs_step(ver_r.hist, taps(cfg.pattern), cfg.width10,
			ver_r.rx_d, 1'b1);
		mism = |((step.word ^ ver_r.rx_d) & mask);
		match = cfg.width10 ? (ver_r.rx_d == ALIGN_PRBS10) :
			({ver_r.rx_prev[7:0], ver_r.rx_d[7:0]} ==
			align16(cfg.pattern));
		// At or past the end, so a pattern change cannot run the count away
		cyc_end = (ver_r.cnt >= cyc - 24'd1);

		ver_nxt.rx_d = rx_src & mask;
		ver_nxt.rx_prev = ver_r.rx_d;
		ver_nxt.hist = step.hist;

		if (!ver_en) begin
			// Done is kept; only rst_b or the receive reset clears it
			ver_nxt.st = VER_IDLE;
			ver_nxt.aligned = 1'b0;
			ver_nxt.err = 1'b0;
			ver_nxt.hold = 2'd0;
			ver_nxt.dirty = 1'b0;
		end else begin
			case (ver_r.st)
				VER_IDLE: begin
					ver_nxt.st = VER_SEARCH;
				end
				VER_SEARCH: begin
					if (match) begin
						ver_nxt.st = VER_WARM;
						ver_nxt.aligned = 1'b1;
						ver_nxt.warm = 2'd0;
					end
				end
				VER_WARM: begin
					// History must fill before any bit can be judged
					if (ver_r.warm == WARM_WORDS - 2'd1) begin
						ver_nxt.st = VER_COUNT;
						ver_nxt.cnt = 24'h000000;
					end else begin
						ver_nxt.warm = ver_r.warm + 2'd1;
					end
				end
				VER_COUNT: begin
					if (cyc_end) begin
						ver_nxt.st = VER_DONE;
						ver_nxt.done = 1'b1;
						ver_nxt.cnt = 24'h000000;
						ver_nxt.dirty = 1'b0;
					end else begin
						ver_nxt.cnt = ver_r.cnt + 24'd1;
					end
				end
				VER_DONE: begin
					ver_nxt.cnt = cyc_end ? 24'h000000 : ver_r.cnt + 24'd1;
					if (ver_r.hold != 2'd0) begin
						ver_nxt.hold = ver_r.hold - 2'd1;
					end
					if (cyc_end) begin
						ver_nxt.dirty = 1'b0;
						if (!ver_r.dirty && !mism && ver_r.hold == 2'd0) begin
							ver_nxt.err = 1'b0;
						end
					end else if (mism) begin
						ver_nxt.dirty = 1'b1;
					end
					// Set after clear so a fresh mismatch always wins
					if (mism) begin
						ver_nxt.err = 1'b1;
						ver_nxt.hold = ERR_HOLD_CYCLES - 2'd1;
					end
				end
				default: ver_nxt.st = VER_IDLE;
			endcase
		end

		if (!rst_b || rx_digitalreset) begin
			ver_nxt = VER_RESET;
		end
	end

	always_ff @(posedge clk) begin
		ver_r <= ver_nxt;
	end

	assign status.done = ver_r.done;
	assign status.err = ver_r.err;
	assign status.aligned = ver_r.aligned;

	// Checks on the verifier and the generator

	property p_done_sticky;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		status.done |=> status.done;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("done dropped without receive reset");

	property p_done_after_count;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		$rose(status.done) |-> $past(ver_r.st == VER_COUNT);
	endproperty
	a_done_after_count: assert property (p_done_after_count)
		else $error("done rose without a counted pattern cycle");

	property p_err_needs_done;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		status.err |-> status.done;
	endproperty
	a_err_needs_done: assert property (p_err_needs_done)
		else $error("error flag before done");

	property p_err_min_three;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		$rose(status.err) && ver_en |=> (status.err || !ver_en) [*2];
	endproperty
	a_err_min_three: assert property (p_err_min_three)
		else $error("error flag shorter than three cycles");

	property p_err_on_mismatch;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		(ver_r.st == VER_DONE) && ver_en && mism |=> status.err;
	endproperty
	a_err_on_mismatch: assert property (p_err_on_mismatch)
		else $error("mismatch after done not flagged");

	property p_no_err_unlocked;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		(ver_r.st != VER_DONE) |-> !status.err;
	endproperty
	a_no_err_unlocked: assert property (p_no_err_unlocked)
		else $error("error flag outside the checking state");

	property p_toggle_unchecked;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		(cfg.pattern == PAT_HIGH || cfg.pattern == PAT_LOW) |=>
			!status.aligned && !status.err;
	endproperty
	a_toggle_unchecked: assert property (p_toggle_unchecked)
		else $error("toggle pattern touched the verifier flags");

	property p_basic_only;
		@(posedge clk) disable iff (!rst_b || tx_digitalreset)
		!cfg.basic_mode |=> (tx_word == WORD_RESET);
	endproperty
	a_basic_only: assert property (p_basic_only)
		else $error("pattern sent outside basic mode");

	property p_width8;
		@(posedge clk) disable iff (!rst_b || tx_digitalreset)
		!cfg.width10 |=> (tx_word[9:8] == 2'b00);
	endproperty
	a_width8: assert property (p_width8)
		else $error("upper bits driven at 8-bit width");

	property p_loopback;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		cfg.loopback_en |=> ver_r.rx_d == ($past(tx_word) & mask);
	endproperty
	a_loopback: assert property (p_loopback)
		else $error("loopback word did not reach the verifier");

	property p_lock_on_align;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		(ver_r.st == VER_SEARCH) && ver_en && match |=>
			(ver_r.st == VER_WARM) && status.aligned;
	endproperty
	a_lock_on_align: assert property (p_lock_on_align)
		else $error("alignment word seen but no lock");

	property p_tx_reset;
		@(posedge clk) tx_digitalreset |=> (tx_word == WORD_RESET);
	endproperty
	a_tx_reset: assert property (p_tx_reset)
		else $error("generator not cleared by transmit reset");

	// Far aligner can only lock if the alignment word leads the sequence
	property p_align_first;
		@(posedge clk) disable iff (!rst_b)
		$fell(tx_digitalreset) && cfg.basic_mode && is_prbs(cfg.pattern) &&
			pattern_ok(cfg.pattern, cfg.width10) |=>
			($past(cfg.width10) ? (tx_word == ALIGN_PRBS10) :
			({tx_word[7:0], 8'h00} ==
			(align16($past(cfg.pattern)) & 16'hff00)));
	endproperty
	a_align_first: assert property (p_align_first)
		else $error("pattern did not open with its alignment word");

	property p_err_locked;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		status.err |-> status.aligned;
	endproperty
	a_err_locked: assert property (p_err_locked)
		else $error("error flag without alignment lock");

	property p_done_locked;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		$rose(status.done) |-> status.aligned;
	endproperty
	a_done_locked: assert property (p_done_locked)
		else $error("done rose before alignment lock");

	property p_count_bound;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		$stable(cfg.pattern) &&
			(ver_r.st == VER_COUNT || ver_r.st == VER_DONE) |->
			(ver_r.cnt < cyc);
	endproperty
	a_count_bound: assert property (p_count_bound)
		else $error("word counter ran past one pattern cycle");

	property p_unsupported_idle;
		@(posedge clk) disable iff (!rst_b || rx_digitalreset)
		!ver_en |=> !status.aligned && !status.err;
	endproperty
	a_unsupported_idle: assert property (p_unsupported_idle)
		else $error("verifier flags active outside a checked mode");

	c_done: cover property (@(posedge clk) $rose(status.done));
	c_err_set: cover property (@(posedge clk) $rose(status.err));
	c_err_clear: cover property (@(posedge clk) $fell(status.err) &&
		status.done);
	c_lock: cover property (@(posedge clk) $rose(status.aligned) &&
		cfg.loopback_en);
	c_done_line: cover property (@(posedge clk) $rose(status.done) &&
		!cfg.loopback_en);

endmodule // prbs_selftest

/* File: bench/serial_line_model.sv */
// Serial line partner returning transmitted words to the receiver
`timescale 1ns/1ps
module serial_line_model (
	// Clock
	input wire logic clk,
	// Words across the line
	input wire logic [9:0] tx_word,
	output logic [9:0] rx_word,
	// Fault controls
	input wire logic inject,
	input wire logic cut
);
	initial rx_word = 10'h000;
	// Broken line toggles so no stale word can look valid
	always @(posedge clk) begin
		if (cut) begin
			rx_word <= ~rx_word;
		end else begin
			rx_word <= tx_word ^ {9'h000, inject};
		end
	end
endmodule // serial_line_model

/* File: bench/prbs_selftest_tb_top.sv */
// Self-checking bench for the pattern self-test block
`timescale 1ns/1ps
module prbs_selftest_tb_top;
	import prbs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic tx_rst = 1'b0;
	logic rx_rst = 1'b0;
	logic inject = 1'b0;
	logic cut = 1'b1;
	selftest_cfg_s cfg = '{PAT_OFF, 1'b0, 1'b1, 1'b0};
	logic [9:0] tx_word;
	logic [9:0] rx_word;
	verify_status_s status;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	pattern_e pats [4] = '{PAT_PRBS7, PAT_PRBS8, PAT_PRBS10, PAT_PRBS23};
	logic wide [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	int degs [4] = '{7, 8, 10, 23};
	int tap_k [4] = '{6, 7, 7, 18};
	logic [15:0] aligns [4] = '{16'h3040, 16'hff5a, 16'h03ff, 16'hffff};
	pattern_e tpat [3] = '{PAT_HIGH, PAT_HIGH, PAT_LOW};
	logic tw10 [3] = '{1'b0, 1'b1, 1'b1};
	logic [9:0] twant [3] = '{10'h055, 10'h155, 10'h01f};
	pattern_e upat [3] = '{PAT_PRBS7, PAT_LOW, PAT_PRBS10};
	logic uw10 [3] = '{1'b1, 1'b0, 1'b1};
	logic ubasic [3] = '{1'b1, 1'b1, 1'b0};

	// Short cycle keeps the degree-23 run brief
	prbs_selftest #(.PRBS23_CYCLE_WORDS(16)) u_prbs_selftest (
		.clk(clk),
		.rst_b(rst_b),
		.tx_digitalreset(tx_rst),
		.rx_digitalreset(rx_rst),
		.cfg(cfg),
		.tx_word(tx_word),
		.rx_word(rx_word),
		.status(status)
	);

	serial_line_model u_serial_line_model (
		.clk(clk),
		.tx_word(tx_word),
		.rx_word(rx_word),
		.inject(inject),
		.cut(cut)
	);

	always #5 clk = ~clk;

	function automatic logic [9:0] ref_word(inout logic [22:0] h,
			input int deg, input int tap, input logic w10);
		logic [9:0] w;
		logic b;
		w = 10'h000;
		for (int i = 0; i < (w10 ? 10 : 8); i++) begin
			b = h[deg - 1] ^ h[tap - 1];
			w[i] = b;
			h = {h[21:0], b};
		end
		return w;
	endfunction

	task automatic chk(input string what, input logic [9:0] got,
			input logic [9:0] want);
		compares++;
		if (got !== want) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, want, got);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Both resets together restart generator and verifier
	task automatic start(input pattern_e p, input logic w10,
			input logic lb, input logic basic);
		@(negedge clk);
		cfg = '{p, w10, basic, lb};
		tx_rst = 1'b1;
		rx_rst = 1'b1;
		@(negedge clk);
		tx_rst = 1'b0;
		rx_rst = 1'b0;
	endtask

	task automatic wait_bit(input logic sel_err, input logic val,
			input int lim, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(negedge clk);
			seen = ((sel_err ? status.err : status.done) === val);
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		logic [22:0] h;
		logic seen;
		logic [9:0] want;
		repeat (3) @(negedge clk);
		chk("reset word", tx_word, 10'h000);
		chk("reset status", {7'h00, status}, 10'h000);
		rst_b = 1'b1;
		// Line is cut, so only the internal loopback can complete
		for (int k = 0; k < 4; k++) begin
			start(pats[k], wide[k], 1'b1, 1'b1);
			h = HIST_SEED;
			@(negedge clk);
			chk("early lock", {9'h000, status.aligned}, 10'h000);
			if (wide[k]) begin
				chk("align", tx_word, aligns[k][9:0]);
			end else begin
				chk("align hi", tx_word, {2'b00, aligns[k][15:8]});
				@(negedge clk);
				chk("align lo", tx_word, {2'b00, aligns[k][7:0]});
			end
			for (int j = 0; j < 12; j++) begin
				@(negedge clk);
				want = ref_word(h, degs[k], tap_k[k], wide[k]);
				chk("prbs", tx_word, want);
			end
			wait_bit(1'b0, 1'b1, 300, seen);
			chk("done", {9'h000, seen}, 10'h001);
			chk("clean err", {9'h000, status.err}, 10'h000);
			chk("locked", {9'h000, status.aligned}, 10'h001);
		end
		for (int k = 0; k < 3; k++) begin
			start(tpat[k], tw10[k], 1'b1, 1'b1);
			repeat (3) @(negedge clk);
			for (int j = 0; j < 3; j++) begin
				@(negedge clk);
				chk("toggle", tx_word, twant[k]);
				chk("toggle flags", {8'h00, status.err, status.aligned}, 10'h000);
			end
		end
		for (int k = 0; k < 3; k++) begin
			start(upat[k], uw10[k], 1'b1, ubasic[k]);
			repeat (4) @(negedge clk);
			chk("refused", tx_word, 10'h000);
		end
		// Error over the real line after completion
		cut = 1'b0;
		start(PAT_PRBS7, 1'b0, 1'b0, 1'b1);
		wait_bit(1'b0, 1'b1, 300, seen);
		chk("line done", {9'h000, seen}, 10'h001);
		inject = 1'b1;
		@(negedge clk);
		inject = 1'b0;
		wait_bit(1'b1, 1'b1, 10, seen);
		chk("err rise", {9'h000, seen}, 10'h001);
		for (int j = 0; j < 2; j++) begin
			@(negedge clk);
			chk("err hold", {9'h000, status.err}, 10'h001);
		end
		wait_bit(1'b1, 1'b0, 60, seen);
		chk("err clear", {9'h000, seen}, 10'h001);
		chk("done sticky", {9'h000, status.done}, 10'h001);
		rx_rst = 1'b1;
		@(negedge clk);
		rx_rst = 1'b0;
		chk("rx reset", {9'h000, status.done}, 10'h000);
		tx_rst = 1'b1;
		@(negedge clk);
		tx_rst = 1'b0;
		chk("tx reset", tx_word, 10'h000);
		give_verdict();
	end
endmodule // prbs_selftest_tb_top
